// *** src/slmf_consts.vh ***
// constants of the synchronous line message framer
// assumes byte-framed line streams; hunting for sync is done upstream
`ifndef SLMF_CONSTS_VH
`define SLMF_CONSTS_VH
// ==========================================================
// message classes and header layout
`define SLMF_CLS_DATA   8'h81
`define SLMF_CLS_CTL    8'h05
`define SLMF_CLS_MNT    8'h90
`define SLMF_CT_ACK     8'h01
`define SLMF_CT_NAK     8'h02
`define SLMF_NR_HDR     8'h01
`define SLMF_NR_BODY    8'h02
`define SLMF_NR_SEQ     8'h03
`define SLMF_FL_RESYNC  0
`define SLMF_FL_TURN    1
`define SLMF_MAX_CNT    16'h3FFF
`define SLMF_CRC_POLY   16'h8005
`define SLMF_CRC_INIT   16'h0000
// ==========================================================
// host commands and responses
`define SLMF_CMD_PROC   2'h0
`define SLMF_CMD_MODE   2'h1
`define SLMF_CMD_CTRL   2'h2
`define SLMF_CMD_BUF    2'h3
`define SLMF_PC_MAINT   0
`define SLMF_PC_INIT    1
`define SLMF_RSP_CTL    2'h0
`define SLMF_RSP_INFO   2'h1
`define SLMF_RSP_DISP   2'h2
`define SLMF_RC_DONE    7'h01
`define SLMF_RC_BADCNT  7'h02
`define SLMF_RC_HDRBCC  7'h03
`define SLMF_RC_SEQ     7'h05
`define SLMF_RC_STATE   7'h06
`define SLMF_RC_CLASS   7'h07
`define SLMF_RC_ACK     7'h10
`define SLMF_RC_NAK     7'h11
`define SLMF_RC_RXOK    7'h20
`define SLMF_RC_TXOK    7'h21
`define SLMF_RC_RXBAD   7'h22
`endif

// *** src/slmf_buf2.v ***
// two-entry elastic buffer, valid/ready both sides
// assumes one clock, synchronous active-high reset
`default_nettype none
module slmf_buf2 #(
   parameter W = 8
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst,
   // filling side
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // draining side
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] m0_r;
   reg [W-1:0] m1_r;
   reg [1:0]   cnt_r;
   wire        push;
   wire        pop;

   // =======================================================
   // handshakes; head entry always in m0
   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = m0_r;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage shifts toward the head on pop
   always @(posedge clk) begin
      if (rst) begin
         cnt_r <= 2'h0;
         m0_r  <= {W{1'b0}};
         m1_r  <= {W{1'b0}};
      end else begin
         case ({push, pop})
            2'b10: begin
               if (cnt_r == 2'h0) m0_r <= in_data;
               else m1_r <= in_data;
               cnt_r <= cnt_r + 2'h1;
            end
            2'b01: begin
               m0_r  <= m1_r;
               cnt_r <= cnt_r - 2'h1;
            end
            2'b11: begin
               if (cnt_r == 2'h1) begin
                  m0_r <= in_data;
               end else begin
                  m0_r <= m1_r;
                  m1_r <= in_data;
               end
            end
            default: ;
         endcase
      end
   end
endmodule // slmf_buf2
`default_nettype wire

// *** src/slmf_framer.v ***
// message framer: builds and checks line messages, host ports
// assumes line bytes arrive already byte-aligned, one clock domain
`include "slmf_consts.vh"
`default_nettype none
module slmf_framer (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // host command port
   input  wire        cmd_req,
   output wire        cmd_grant,
   input  wire        cmd_wr,
   input  wire [1:0]  cmd_type,
   input  wire [15:0] cmd_data,
   // host response port
   output reg         rsp_valid_r,
   output reg  [1:0]  rsp_type_r,
   output reg  [7:0]  rsp_code_r,
   output reg  [15:0] rsp_data_r,
   input  wire        rsp_ack,
   // transmit body from host memory
   input  wire        txb_valid,
   output wire        txb_ready,
   input  wire [7:0]  txb_data,
   // received body to host memory
   output reg         rxb_valid_r,
   input  wire        rxb_ready,
   output reg  [7:0]  rxb_data_r,
   // line transmit
   output wire        ltx_valid,
   input  wire        ltx_ready,
   output wire [7:0]  ltx_data,
   // line receive
   input  wire        lrx_valid,
   output wire        lrx_ready,
   input  wire [7:0]  lrx_data,
   // state
   output reg         maint_r,
   output reg  [7:0]  addr_r
);
   localparam T_IDLE = 5'b00001;
   localparam T_HDR  = 5'b00010;
   localparam T_BODY = 5'b00100;
   localparam T_BCC  = 5'b01000;
   localparam T_CTL  = 5'b10000;
   localparam R_HDR  = 3'b001;
   localparam R_BODY = 3'b010;
   localparam R_BCC  = 3'b100;

   // =======================================================
   // crc over one byte, msb first, no final inversion
   function [15:0] crc8;
      input [15:0] c;
      input [7:0]  d;
      integer      i;
      reg   [15:0] x;
      begin
         x = c;
         for (i = 0; i < 8; i = i + 1) begin
            if (x[15] ^ d[7-i]) x = {x[14:0], 1'b0} ^ `SLMF_CRC_POLY;
            else x = {x[14:0], 1'b0};
         end
         crc8 = x;
      end
   endfunction

   reg  [4:0]  tx_st_r;
   reg  [15:0] tx_idx_r;
   reg  [15:0] tx_cnt_r;
   reg  [15:0] tx_crc_r;
   reg  [7:0]  tx_seq_r;
   reg  [1:0]  flags_r;
   reg         tx_req_r;
   reg         tx_mnt_r;
   reg         ctl_pend_r;
   reg  [7:0]  ctl_type_r;
   reg  [7:0]  ctl_num_r;
   reg  [2:0]  rx_st_r;
   reg  [15:0] rx_idx_r;
   reg  [15:0] rx_cnt_r;
   reg  [15:0] rx_crc_r;
   reg  [47:0] rhdr_r;
   reg         rx_dlv_r;
   reg         rx_mnt_r;
   reg  [7:0]  rx_exp_r;
   reg  [7:0]  rx_seq_r;
   reg         lost_r;
   reg  [7:0]  tx_byte;
   reg         tx_emit;
   wire        buf_in_ready;
   wire        tx_push;
   wire        tx_done;
   wire        ctl_start;
   wire        cmd_take;
   wire        cmd_init;
   wire [15:0] rx_crc_nxt;
   wire        rx_take;

   // =======================================================
   // command port
   // grant only while nothing waits, so no command is dropped
   assign cmd_grant = cmd_req & ~tx_req_r & (tx_st_r == T_IDLE) & ~rsp_valid_r;
   assign cmd_take  = cmd_wr & cmd_grant;
   assign cmd_init  = cmd_take & (cmd_type == `SLMF_CMD_PROC) & cmd_data[`SLMF_PC_INIT];

   // all four command types decoded here
   always @(posedge clk) begin
      if (rst) begin
         maint_r  <= 1'b0;
         addr_r   <= 8'h00;
         flags_r  <= 2'h0;
         tx_req_r <= 1'b0;
         tx_mnt_r <= 1'b0;
         tx_cnt_r <= 16'h0000;
      end else begin
         if (tx_st_r == T_HDR) tx_req_r <= 1'b0;
         if (tx_done) flags_r <= 2'h0;   // flags apply to one message
         if (cmd_take) begin
            case (cmd_type)
               `SLMF_CMD_PROC: maint_r <= cmd_data[`SLMF_PC_MAINT];
               `SLMF_CMD_MODE: addr_r <= cmd_data[7:0];
               `SLMF_CMD_CTRL: flags_r <= cmd_data[1:0];
               `SLMF_CMD_BUF: begin
                  if (cmd_data != 16'h0000 && cmd_data <= `SLMF_MAX_CNT) begin
                     tx_req_r <= 1'b1;
                     tx_mnt_r <= maint_r;
                     tx_cnt_r <= cmd_data;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // =======================================================
   // transmit byte selection
   always @* begin
      tx_byte = 8'h00;
      tx_emit = 1'b0;
      case (tx_st_r)
         T_HDR, T_CTL: begin
            tx_emit = 1'b1;
            case (tx_idx_r[2:0])
               3'h0: tx_byte = (tx_st_r == T_CTL) ? `SLMF_CLS_CTL :
                               (tx_mnt_r ? `SLMF_CLS_MNT : `SLMF_CLS_DATA);
               3'h1: tx_byte = (tx_st_r == T_CTL) ? ctl_type_r : tx_cnt_r[7:0];
               3'h2: tx_byte = (tx_st_r == T_CTL) ? 8'h00 : tx_cnt_r[15:8];
               3'h3: tx_byte = (tx_st_r == T_CTL) ? 8'h00 : {6'h00, flags_r};
               3'h4: tx_byte = (tx_st_r == T_CTL) ? ctl_num_r : tx_seq_r;
               3'h5: tx_byte = addr_r;
               3'h6: tx_byte = tx_crc_r[15:8];
               default: tx_byte = tx_crc_r[7:0];
            endcase
         end
         T_BODY: begin
            tx_emit = txb_valid;
            tx_byte = txb_data;
         end
         T_BCC: begin
            tx_emit = 1'b1;
            tx_byte = tx_idx_r[0] ? tx_crc_r[7:0] : tx_crc_r[15:8];
         end
         default: ;
      endcase
   end

   // body bytes flow straight on; buffer absorbs line stalls
   assign tx_push   = tx_emit & buf_in_ready;
   assign txb_ready = (tx_st_r == T_BODY) & buf_in_ready;
   assign ctl_start = (tx_st_r == T_IDLE) & ctl_pend_r;
   assign tx_done   = (tx_st_r == T_BCC) & tx_push & tx_idx_r[0];

   // transmit sequencer: header first, then host body, then check
   always @(posedge clk) begin
      if (rst) begin
         tx_st_r  <= T_IDLE;
         tx_idx_r <= 16'h0000;
         tx_crc_r <= `SLMF_CRC_INIT;
         tx_seq_r <= 8'h00;
      end else begin
         if (cmd_init) tx_seq_r <= 8'h00;
         case (tx_st_r)
            T_IDLE: begin
               tx_idx_r <= 16'h0000;
               tx_crc_r <= `SLMF_CRC_INIT;
               if (ctl_pend_r) tx_st_r <= T_CTL;
               else if (tx_req_r) tx_st_r <= T_HDR;
            end
            T_HDR, T_CTL: begin
               if (tx_push) begin
                  if (tx_idx_r < 16'h0006) tx_crc_r <= crc8(tx_crc_r, tx_byte);
                  if (tx_idx_r == 16'h0007) begin
                     tx_idx_r <= 16'h0000;
                     tx_crc_r <= `SLMF_CRC_INIT;
                     tx_st_r  <= (tx_st_r == T_CTL) ? T_IDLE : T_BODY;
                  end else begin
                     tx_idx_r <= tx_idx_r + 16'h0001;
                  end
               end
            end
            T_BODY: begin
               if (tx_push) begin
                  tx_crc_r <= crc8(tx_crc_r, tx_byte);
                  if (tx_idx_r == tx_cnt_r - 16'h0001) begin
                     tx_idx_r <= 16'h0000;
                     tx_st_r  <= T_BCC;
                  end else begin
                     tx_idx_r <= tx_idx_r + 16'h0001;
                  end
               end
            end
            T_BCC: begin
               if (tx_push) begin
                  tx_idx_r <= tx_idx_r + 16'h0001;
                  if (tx_idx_r[0]) begin
                     tx_st_r <= T_IDLE;
                     if (!tx_mnt_r) tx_seq_r <= tx_seq_r + 8'h01;
                  end
               end
            end
            default: tx_st_r <= T_IDLE;
         endcase
      end
   end

   slmf_buf2 #(.W(8)) u_txbuf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (tx_emit),
      .in_ready  (buf_in_ready),
      .in_data   (tx_byte),
      .out_valid (ltx_valid),
      .out_ready (ltx_ready),
      .out_data  (ltx_data)
   );

   // =======================================================
   // receive side decode
   wire [7:0]  h_cls = rhdr_r[47:40];
   wire [7:0]  h_b1  = rhdr_r[39:32];
   wire [15:0] h_cnt = {rhdr_r[31:24], rhdr_r[39:32]};
   wire [7:0]  h_num = rhdr_r[15:8];
   wire [7:0]  h_adr = rhdr_r[7:0];
   wire        h_end = (rx_st_r == R_HDR) & rx_take & (rx_idx_r == 16'h0007);
   wire        b_end = (rx_st_r == R_BCC) & rx_take & rx_idx_r[0];
   // back-pressure while a delivered byte is stuck; check bytes wait too,
   // so the disposition never overtakes the last byte handed to the host
   assign lrx_ready  = ~(rx_dlv_r & rxb_valid_r & ~rxb_ready);
   assign rx_take    = lrx_valid & lrx_ready;
   assign rx_crc_nxt = crc8(rx_crc_r, lrx_data);

   reg        go_body;
   reg        go_dlv;
   reg        ack_set;
   reg        nak_set;
   reg [7:0]  nak_why;
   reg        rx_ev;
   reg [1:0]  rx_ev_type;
   reg [6:0]  rx_ev_code;
   reg [15:0] rx_ev_data;

   // header and body verdicts
   always @* begin
      go_body    = 1'b0;
      go_dlv     = 1'b0;
      ack_set    = 1'b0;
      nak_set    = 1'b0;
      nak_why    = `SLMF_NR_HDR;
      rx_ev      = 1'b0;
      rx_ev_type = `SLMF_RSP_CTL;
      rx_ev_code = `SLMF_RC_CLASS;
      rx_ev_data = {8'h00, h_cls};
      if (h_end) begin
         if (rx_crc_nxt != 16'h0000) begin
            rx_ev      = 1'b1;
            rx_ev_code = `SLMF_RC_HDRBCC;
            nak_set    = ~maint_r;
         end else if (h_cls == `SLMF_CLS_CTL) begin
            if (maint_r) begin
               rx_ev      = 1'b1;
               rx_ev_code = `SLMF_RC_STATE;
            end else if (h_adr == addr_r) begin
               rx_ev      = 1'b1;
               rx_ev_type = `SLMF_RSP_INFO;
               rx_ev_data = {8'h00, h_num};
               if (h_b1 == `SLMF_CT_ACK) rx_ev_code = `SLMF_RC_ACK;
               else if (h_b1 == `SLMF_CT_NAK) rx_ev_code = `SLMF_RC_NAK;
               else rx_ev_type = `SLMF_RSP_CTL;
            end
         end else if (h_cls == `SLMF_CLS_DATA || h_cls == `SLMF_CLS_MNT) begin
            if (h_cnt == 16'h0000 || h_cnt > `SLMF_MAX_CNT) begin
               rx_ev      = 1'b1;
               rx_ev_code = `SLMF_RC_BADCNT;
               rx_ev_data = h_cnt;
               nak_set    = ~maint_r;
            end else if (h_adr != addr_r) begin
               go_body = 1'b1;   // not ours: count past it quietly
            end else if ((h_cls == `SLMF_CLS_MNT) != maint_r) begin
               go_body    = 1'b1;
               rx_ev      = 1'b1;
               rx_ev_code = `SLMF_RC_STATE;
            end else if (!maint_r && h_num != rx_exp_r) begin
               go_body    = 1'b1;
               rx_ev      = 1'b1;
               rx_ev_code = `SLMF_RC_SEQ;
               rx_ev_data = {8'h00, h_num};
               nak_set    = 1'b1;
               nak_why    = `SLMF_NR_SEQ;
            end else begin
               go_body = 1'b1;
               go_dlv  = 1'b1;
            end
         end else begin
            rx_ev = 1'b1;
         end
      end else if (b_end && rx_dlv_r) begin
         rx_ev      = 1'b1;
         rx_ev_type = `SLMF_RSP_DISP;
         rx_ev_data = rx_cnt_r;
         if (rx_crc_nxt == 16'h0000) begin
            rx_ev_code = `SLMF_RC_RXOK;
            ack_set    = ~rx_mnt_r;
         end else begin
            rx_ev_code = `SLMF_RC_RXBAD;
            nak_set    = ~rx_mnt_r;
            nak_why    = `SLMF_NR_BODY;
         end
      end
   end

   // receive sequencer; header held until the next header shifts in
   always @(posedge clk) begin
      if (rst) begin
         rx_st_r     <= R_HDR;
         rx_idx_r    <= 16'h0000;
         rx_cnt_r    <= 16'h0000;
         rx_crc_r    <= `SLMF_CRC_INIT;
         rhdr_r      <= 48'h000000000000;
         rx_dlv_r    <= 1'b0;
         rx_mnt_r    <= 1'b0;
         rx_exp_r    <= 8'h00;
         rx_seq_r    <= 8'h00;
         rxb_valid_r <= 1'b0;
         rxb_data_r  <= 8'h00;
      end else begin
         if (rxb_ready) rxb_valid_r <= 1'b0;
         if (cmd_init) rx_exp_r <= 8'h00;
         if (ack_set) rx_exp_r <= rx_seq_r + 8'h01;
         if (rx_take) begin
            rx_crc_r <= rx_crc_nxt;
            rx_idx_r <= rx_idx_r + 16'h0001;
            case (rx_st_r)
               R_HDR: begin
                  if (rx_idx_r < 16'h0006) rhdr_r <= {rhdr_r[39:0], lrx_data};
                  if (h_end) begin
                     rx_idx_r <= 16'h0000;
                     rx_crc_r <= `SLMF_CRC_INIT;
                     rx_cnt_r <= h_cnt;
                     rx_dlv_r <= go_dlv;
                     rx_mnt_r <= (h_cls == `SLMF_CLS_MNT);
                     rx_seq_r <= h_num;
                     if (go_body) rx_st_r <= R_BODY;
                  end
               end
               R_BODY: begin
                  if (rx_dlv_r) begin
                     rxb_valid_r <= 1'b1;
                     rxb_data_r  <= lrx_data;
                  end
                  if (rx_idx_r == rx_cnt_r - 16'h0001) begin
                     rx_idx_r <= 16'h0000;
                     rx_st_r  <= R_BCC;
                  end
               end
               R_BCC: begin
                  if (rx_idx_r[0]) begin
                     rx_idx_r <= 16'h0000;
                     rx_crc_r <= `SLMF_CRC_INIT;
                     rx_dlv_r <= 1'b0;   // delivery flag dropped here; rhdr_r is kept
                     rx_st_r  <= R_HDR;
                  end
               end
               default: rx_st_r <= R_HDR;
            endcase
         end
      end
   end

   // pending acknowledgement; a new verdict overrides an unsent one
   always @(posedge clk) begin
      if (rst) begin
         ctl_pend_r <= 1'b0;
         ctl_type_r <= 8'h00;
         ctl_num_r  <= 8'h00;
      end else begin
         ctl_pend_r <= ack_set | nak_set | (ctl_pend_r & ~ctl_start);
         if (ack_set | nak_set) begin
            ctl_type_r <= nak_set ? `SLMF_CT_NAK : `SLMF_CT_ACK;
            ctl_num_r  <= nak_set ? nak_why : rx_seq_r;
         end
      end
   end

   // =======================================================
   // response register; receive beats transmit beats commands
   wire cmd_ev = cmd_take & ((cmd_type == `SLMF_CMD_PROC) |
                 ((cmd_type == `SLMF_CMD_BUF) &
                  (cmd_data == 16'h0000 || cmd_data > `SLMF_MAX_CNT)));
   wire ev_any = rx_ev | tx_done | cmd_ev;
   wire multi  = (rx_ev & tx_done) | (rx_ev & cmd_ev) | (tx_done & cmd_ev);
   wire load   = ev_any & (~rsp_valid_r | rsp_ack);
   wire lost_s = multi | (ev_any & rsp_valid_r & ~rsp_ack);

   always @(posedge clk) begin
      if (rst) begin
         rsp_valid_r <= 1'b0;
         rsp_type_r  <= `SLMF_RSP_CTL;
         rsp_code_r  <= 8'h00;
         rsp_data_r  <= 16'h0000;
         lost_r      <= 1'b0;
      end else begin
         lost_r <= lost_s | (lost_r & ~load);   // set wins over clear
         if (load) begin
            rsp_valid_r <= 1'b1;
            if (rx_ev) begin
               rsp_type_r <= rx_ev_type;
               rsp_code_r <= {lost_r | multi, rx_ev_code};
               rsp_data_r <= rx_ev_data;
            end else if (tx_done) begin
               rsp_type_r <= `SLMF_RSP_DISP;
               rsp_code_r <= {lost_r, `SLMF_RC_TXOK};
               rsp_data_r <= tx_cnt_r;
            end else begin
               rsp_type_r <= `SLMF_RSP_CTL;
               rsp_code_r <= {lost_r, (cmd_type == `SLMF_CMD_BUF) ?
                              `SLMF_RC_BADCNT : `SLMF_RC_DONE};
               rsp_data_r <= cmd_data;
            end
         end else if (rsp_ack) begin
            rsp_valid_r <= 1'b0;
         end
      end
   end
endmodule // slmf_framer
`default_nettype wire

// *** bench/slmf_framer_assertions.sv ***
// checker: port properties of the line message framer
// assumes a bind onto slmf_framer, one clock, sync reset
`default_nettype none
// ==========
// checker
module slmf_chk (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // host side
   input wire logic        cmd_grant,
   input wire logic        cmd_wr,
   input wire logic [1:0]  cmd_type,
   input wire logic [15:0] cmd_data,
   input wire logic        rsp_valid_r,
   input wire logic [7:0]  rsp_code_r,
   input wire logic        rsp_ack,
   input wire logic        rxb_valid_r,
   input wire logic        rxb_ready,
   input wire logic [7:0]  rxb_data_r,
   input wire logic        maint_r,
   // line side
   input wire logic        ltx_valid,
   input wire logic        ltx_ready,
   input wire logic [7:0]  ltx_data,
   input wire logic        lrx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // command taken, then the control response it earns
   sequence s_take(t);
      cmd_wr && cmd_grant && cmd_type == t;
   endsequence
   sequence s_done(c);
      rsp_valid_r && rsp_code_r[6:0] == c;
   endsequence
   // zero or over-limit counts are refused
   wire bad_cnt = cmd_data == 16'h0000 || cmd_data > 16'h3FFF;
   chk_proc_done: assert property (s_take(2'h0) |=> s_done(7'h01))
      else $error("processor command not answered");
   chk_state_set: assert property (s_take(2'h0) |=> maint_r == $past(cmd_data[0]))
      else $error("protocol state not taken from command");
   chk_count_refused: assert property (s_take(2'h3) ##0 bad_cnt |=> s_done(7'h02))
      else $error("bad count not refused");
   chk_tx_busy: assert property (s_take(2'h3) ##0 !bad_cnt |=> !cmd_grant)
      else $error("grant while transmit queued");
   chk_rsp_stands: assert property (rsp_valid_r && !rsp_ack |=> rsp_valid_r)
      else $error("response dropped before ack");
   chk_grant_blocked: assert property (rsp_valid_r |-> !cmd_grant)
      else $error("grant with response pending");
   chk_line_hold: assert property (ltx_valid && !ltx_ready |=> ltx_valid && $stable(ltx_data))
      else $error("line byte changed while stalled");
   chk_host_hold: assert property (rxb_valid_r && !rxb_ready |=> rxb_valid_r && $stable(rxb_data_r))
      else $error("host byte changed while stalled");
   chk_rx_backpres: assert property (!lrx_ready |-> rxb_valid_r)
      else $error("line receive stalled without cause");
endmodule // slmf_chk
bind slmf_framer slmf_chk u_chk (.clk, .rst, .cmd_grant, .cmd_wr, .cmd_type, .cmd_data,
   .rsp_valid_r, .rsp_code_r, .rsp_ack, .rxb_valid_r, .rxb_ready, .rxb_data_r, .maint_r,
   .ltx_valid, .ltx_ready, .ltx_data, .lrx_ready);
`default_nettype wire

// *** bench/slmf_line_peer.sv ***
// partner: remote controller on the byte-aligned line
// assumes the testbench fills tx_q and reads got_q
`default_nettype none
// ==========
// line peer
module slmf_peer (
   // clock
   input wire logic       clk,
   // bytes toward the framer
   output logic           lrx_valid,
   output logic [7:0]     lrx_data,
   input wire logic       lrx_ready,
   // bytes from the framer
   input wire logic       ltx_valid,
   input wire logic [7:0] ltx_data,
   output logic           ltx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  tx_q[$];
   logic [7:0]  got_q[$];
   logic [31:0] seed = 32'h5B17;
   initial begin
      lrx_valid = 1'b0;
      lrx_data = 8'h00;
      ltx_ready = 1'b0;
   end
   // each byte held until taken; idle data churns so stale values never match
   always @(posedge clk) begin
      ltx_ready <= ($random(seed) & 3) != 0;
      if (ltx_valid && ltx_ready) got_q.push_back(ltx_data);
      if (lrx_valid && lrx_ready) void'(tx_q.pop_front());
      if (!lrx_valid || lrx_ready) begin
         lrx_valid <= tx_q.size() > 0;
         lrx_data  <= tx_q.size() > 0 ? tx_q[0] : ~lrx_data;
      end
   end
endmodule // slmf_peer
`default_nettype wire

// *** bench/testbench.sv ***
// testbench: host driver and byte-queue model of the framer
// assumes the line peer model and the bound checker
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
// ==========
// top
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst = 1'b1, cmd_req = 1'b0, cmd_wr = 1'b0, rsp_ack = 1'b0;
   logic        txb_valid = 1'b0, rxb_ready = 1'b0, cmd_grant, rsp_valid_r, txb_ready;
   logic        rxb_valid_r, ltx_valid, ltx_ready, lrx_valid, lrx_ready, maint_r;
   logic [1:0]  cmd_type = 2'h0, rsp_type_r;
   logic [15:0] cmd_data = 16'h0000, rsp_data_r;
   logic [7:0]  txb_data = 8'h00, rsp_code_r, rxb_data_r, ltx_data, lrx_data, addr_r;
   logic [7:0]  txq[$], rxq[$], expq[$], body[$];
   logic [31:0] seed = 32'h5B17;
   int          num_errors = 0, samples_checked = 0, cycles = 0;
   always #5 clk = ~clk;
   slmf_framer u_dut (.clk, .rst, .cmd_req, .cmd_grant, .cmd_wr, .cmd_type, .cmd_data,
      .rsp_valid_r, .rsp_type_r, .rsp_code_r, .rsp_data_r, .rsp_ack, .txb_valid, .txb_ready,
      .txb_data, .rxb_valid_r, .rxb_ready, .rxb_data_r, .ltx_valid, .ltx_ready, .ltx_data,
      .lrx_valid, .lrx_ready, .lrx_data, .maint_r, .addr_r);
   slmf_peer u_peer (.clk, .lrx_valid, .lrx_data, .lrx_ready, .ltx_valid, .ltx_data, .ltx_ready);
   // check field: msb first, no final inversion
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'h0000;
      foreach (q[i]) for (int b = 7; b >= 0; b--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? 16'h8005 : 16'h0000);
      return c;
   endfunction
   // append bytes and their check field, high byte first
   function automatic void add(ref logic [7:0] q[$], input logic [7:0] a[$]);
      logic [15:0] c;
      c = crc16(a);
      foreach (a[i]) q.push_back(a[i]);
      q.push_back(c[15:8]);
      q.push_back(c[7:0]);
   endfunction
   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one command, held until the grant is sampled; one idle edge after it
   task automatic cmd(input logic [1:0] t, input logic [15:0] d);
      cmd_req <= 1'b1;
      cmd_wr <= 1'b1;
      cmd_type <= t;
      cmd_data <= d;
      do @(posedge clk); while (cmd_grant !== 1'b1);
      cmd_req <= 1'b0;
      cmd_wr <= 1'b0;
      @(posedge clk);
   endtask
   // await a response, compare, consume it
   task automatic rsp(input logic [1:0] t, input logic [6:0] c, input logic [15:0] d);
      do @(posedge clk); while (rsp_valid_r !== 1'b1);
      `CHK({rsp_type_r, rsp_code_r[6:0]}, {t, c})
      if (t == 2'h2) `CHK(rsp_data_r, d)
      rsp_ack <= 1'b1;
      @(posedge clk);
      rsp_ack <= 1'b0;
   endtask
   // peer sends header plus n random body bytes, body check optionally broken
   task automatic send(input logic [7:0] h[$], input int n, input bit bad);
      @(negedge clk);
      body = {};
      repeat (n) body.push_back(8'($random(seed)));
      add(u_peer.tx_q, h);
      add(u_peer.tx_q, body);
      if (bad) u_peer.tx_q[$] = ~u_peer.tx_q[$];
   endtask
   // host memory: receive side drained at random pace, transmit bytes offered as soon as queued; run-length ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      rxb_ready <= 1'($random(seed));
      if (rxb_valid_r && rxb_ready) rxq.push_back(rxb_data_r);
      if (txb_valid && txb_ready) void'(txq.pop_front());
      if (!txb_valid || txb_ready) begin
         txb_valid <= txq.size() > 0;
         txb_data  <= txq.size() > 0 ? txq[0] : ~txb_data;
      end
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cmd(2'h0, 16'h0001);
      rsp(2'h0, 7'h01, 16'h0000);
      `CHK(maint_r, 1'b1)
      cmd(2'h1, 16'h002A);
      @(posedge clk);
      `CHK(addr_r, 8'h2A)
      send('{8'h81, 8'h01, 8'h00, 8'h00, 8'h00, 8'h2A}, 1, 0);
      rsp(2'h0, 7'h06, 16'h0000);
      cmd(2'h0, 16'h0002);
      rsp(2'h0, 7'h01, 16'h0000);
      cmd(2'h3, 16'h0000);
      rsp(2'h0, 7'h02, 16'h0000);
      cmd(2'h3, 16'h4000);
      rsp(2'h0, 7'h02, 16'h0000);
      cmd(2'h2, 16'h0003);
      txq = '{8'h00, 8'hFF, 8'h5A};
      add(expq, '{8'h81, 8'h03, 8'h00, 8'h03, 8'h00, 8'h2A});
      add(expq, txq);
      cmd(2'h3, 16'h0003);
      rsp(2'h2, 7'h21, 16'h0003);
      rxq = {};
      send('{8'h81, 8'h02, 8'h00, 8'h00, 8'h00, 8'h2A}, 2, 0);
      rsp(2'h2, 7'h20, 16'h0002);
      `CHK({rxq.size(), rxq[0], rxq[1]}, {32'd2, body[0], body[1]})
      add(expq, '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h2A});
      send('{8'h81, 8'h02, 8'h00, 8'h00, 8'h01, 8'h2A}, 2, 1);
      rsp(2'h2, 7'h22, 16'h0002);
      add(expq, '{8'h05, 8'h02, 8'h00, 8'h00, 8'h02, 8'h2A});
      send('{8'h81, 8'h01, 8'h00, 8'h00, 8'h05, 8'h2A}, 1, 0);
      rsp(2'h0, 7'h05, 16'h0000);
      @(negedge clk);
      add(u_peer.tx_q, '{8'h05, 8'h01, 8'h00, 8'h00, 8'h07, 8'h2A});
      rsp(2'h1, 7'h10, 16'h0007);
      add(expq, '{8'h05, 8'h02, 8'h00, 8'h00, 8'h03, 8'h2A});
      repeat (300) if (u_peer.got_q.size() < expq.size()) @(posedge clk);
      `CHK(u_peer.got_q.size(), expq.size())
      foreach (expq[i]) `CHK(u_peer.got_q[i], expq[i])
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
